/* logic/i2c_slv_pkg.sv */
// Shared constants for the two-wire slave: register map, field positions,
// reset values, mode codes and the protocol state enumeration.
// Assumes an APB register bus with 32-bit data and byte addresses.
package i2c_slv_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0c;
	localparam logic [7:0] OFS_TOUT = 8'h10;
	// ----------------------------------------
	// Reset values, write masks and keep mask
	// ----------------------------------------
	localparam logic [7:0] CTRL_RST   = 8'he0;
	localparam logic [7:0] CTRL_WMASK = 8'hee;
	localparam logic [7:0] STAT_RST   = 8'h81;
	localparam logic [7:0] STAT_WMASK = 8'h1e;
	localparam logic [7:0] STAT_KEEP  = 8'h1a;
	localparam logic [7:0] ADDR_RST   = 8'h00;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MODE_LSB  = 5;
	localparam int DEB_LSB   = 2;
	localparam int EN_BIT    = 1;
	localparam int HCF_BIT   = 7;
	localparam int ADDR_MATCHED_FLAG_BIT  = 6;
	localparam int BUSY_BIT  = 5;
	localparam int XMIT_BIT  = 4;
	localparam int ACK_SEND_CTRL_BIT  = 3;
	localparam int DIR_BIT   = 2;
	localparam int WAKE_BIT  = 1;
	localparam int ACK_RECV_FLAG_BIT  = 0;
	localparam int TOF_BIT   = 6;
	localparam int IRQEN_BIT = 0;
	// ----------------------------------------
	// Codes and counts
	// ----------------------------------------
	localparam logic [2:0] MODE_I2C  = 3'b110;
	localparam logic [2:0] DEB_NONE  = 3'h1;
	localparam logic [2:0] DEB_TWO   = 3'h2;
	localparam logic [2:0] DEB_FOUR  = 3'h4;
	localparam logic [3:0] ADDR_LAST = 4'h7;
	localparam logic [3:0] RX_BITS   = 4'h8;
	localparam logic [3:0] TX_LAST   = 4'h7;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_HOLD,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK
	} i2c_state_e;
endpackage

/* logic/line_filter.sv */
// Two-flop synchroniser and selectable debounce for the bus lines.
// Assumes lines arrive asynchronously to pclk; sel comes from pclk logic.
`timescale 1ns/100ps
module line_filter #(
	parameter int W = 2
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [1:0]   sel,
	input  wire logic [W-1:0] din,
	output logic [W-1:0]      dout
);
	typedef struct packed {
		logic [W-1:0]      s1;
		logic [W-1:0]      s2;
		logic [W-1:0]      q;
		logic [W-1:0][2:0] cnt;
	} filt_s;

	filt_s q;
	filt_s next_q;
	logic [2:0] need;

	// Stable cycles before a change is accepted
	always_comb
	begin
		case (sel)
			2'b00:   need = i2c_slv_pkg::DEB_NONE;
			2'b01:   need = i2c_slv_pkg::DEB_TWO;
			default: need = i2c_slv_pkg::DEB_FOUR;
		endcase
	end

	always_comb
	begin
		next_q = q;
		next_q.s1 = din;
		next_q.s2 = q.s1;
		for (int i = 0; i < W; i++)
		begin
			if (q.s2[i] == q.q[i])
				next_q.cnt[i] = 3'h0;
			else if (q.cnt[i] + 3'h1 >= need)
			begin
				next_q.q[i] = q.s2[i];
				next_q.cnt[i] = 3'h0;
			end
			else
				next_q.cnt[i] = q.cnt[i] + 3'h1;
		end
	end

	// Idle bus lines are high, so reset to high avoids a false edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '{s1: '1, s2: '1, q: '1, cnt: '0};
		else
			q <= next_q;
	end

	assign dout = q.q;
endmodule

/* logic/bus_cond_detect.sv */
// Finds clock edges and start/stop conditions on the filtered lines.
// Assumes scl and sda are already synchronised to pclk.
`timescale 1ns/100ps
module bus_cond_detect (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic scl,
	input  wire logic sda,
	output logic      start_det,
	output logic      stop_det,
	output logic      scl_rise,
	output logic      scl_fall
);
	typedef struct packed {
		logic scl;
		logic sda;
	} prev_s;

	prev_s q;
	prev_s next_q;

	always_comb
	begin
		next_q.scl = scl;
		next_q.sda = sda;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '{scl: 1'b1, sda: 1'b1};
		else
			q <= next_q;
	end

	assign start_det = q.scl & scl & q.sda & ~sda;
	assign stop_det  = q.scl & scl & ~q.sda & sda;
	assign scl_rise  = ~q.scl & scl;
	assign scl_fall  = q.scl & ~scl;
endmodule

/* logic/i2c_slave.sv */
// Two-wire bus slave with address match, acknowledge and clock hold,
// reached over APB. Assumes an external bus master and a time-out counter
// elsewhere that pulses timeout_evt on pclk; pins are open drain.
//
// Notes on behaviour
// (R1) Receiver drives acknowledge-control bit on 9th clock; 0 acks, 1 withholds.
// (R2) Acknowledge-control bit is never auto-cleared; firmware clears it. Here a time-out resets it to 0 with the rest of the status.
// (R3) Bit after the address is captured into the direction flag.
// (R4) Direction 0 means master writes, 1 means master reads.
// (R5) With wake enable set, an address match in low power raises wake.
// (R6) Wake enable stays set until firmware clears it. Here a time-out also clears it with the rest of the status.
// (R7) Transmitter samples data line at 9th clock into received-acknowledge flag.
// (R8) Transmitter continues on acknowledge, releases data line on no acknowledge.
// (R9) First seven bits after start, MSB first, are compared with own address.
// (R10) Address match sets matched flag and raises the interrupt request.
// (R11) Matched address plus direction bit is acknowledged low on 9th bit.
// (R12) One interrupt for address match, byte done and time-out.
// (R13) Start is data falling while clock high; sets bus-busy flag.
// (R14) Slave never makes a start; data line only changes with clock low.
// (R15) Block works only with mode 110 and interface enable 1.
// (R16) After a match, clock is held low until data register access.
// (R17) Own address sits in upper seven bits; bit 0 is ignored.
// (R18) Debounce selects none, two or four clock cycles.
// (R19) Data bytes are eight bits, MSB first.
// (R20) Clock is also held low after each acknowledged data byte.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
module i2c_slave (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        low_power,
	input  wire logic        timeout_evt,
	output logic             irq_req,
	output logic             wake_req
);
	typedef struct packed {
		i2c_slv_pkg::i2c_state_e st;
		logic [3:0]              cnt;
		logic [7:0]              shift;
		logic [7:0]              ctrl;
		logic [7:0]              stat;
		logic [7:0]              own;
		logic [7:0]              data;
		logic                    tof;
		logic                    irq_en;
		logic                    sda_oe;
		logic                    scl_oe;
		logic                    irq;
		logic                    wake;
		logic [31:0]             prdata;
	} slv_s;

	slv_s q;
	slv_s next_q;

	logic       scl_f;
	logic       sda_f;
	logic       start_det;
	logic       stop_det;
	logic       scl_rise;
	logic       scl_fall;
	logic       active;
	logic       setup;
	logic       acc;
	logic       mapped;
	logic       data_wr;
	logic       data_rd;
	logic [7:0] rd_val;

	// ----------------------------------------
	// Line conditioning
	// ----------------------------------------
	line_filter #(
		.W (2)
	) u_filter (
		.pclk    (pclk),
		.presetn (presetn),
		.sel     (q.ctrl[i2c_slv_pkg::DEB_LSB +: 2]), // [R18]
		.din     ({scl_i, sda_i}),
		.dout    ({scl_f, sda_f})
	);

	bus_cond_detect u_cond (
		.pclk      (pclk),
		.presetn   (presetn),
		.scl       (scl_f),
		.sda       (sda_f),
		.start_det (start_det),
		.stop_det  (stop_det),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall)
	);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign active = q.ctrl[i2c_slv_pkg::EN_BIT] &&
		q.ctrl[i2c_slv_pkg::MODE_LSB +: 3] == i2c_slv_pkg::MODE_I2C; // [R15]
	assign setup  = psel & ~penable;
	assign acc    = psel & penable;
	assign mapped = paddr == i2c_slv_pkg::OFS_CTRL || paddr == i2c_slv_pkg::OFS_STAT ||
		paddr == i2c_slv_pkg::OFS_ADDR || paddr == i2c_slv_pkg::OFS_DATA ||
		paddr == i2c_slv_pkg::OFS_TOUT;
	assign data_wr = acc & pwrite & (paddr == i2c_slv_pkg::OFS_DATA);
	assign data_rd = acc & ~pwrite & (paddr == i2c_slv_pkg::OFS_DATA);

	always_comb
	begin
		case (paddr)
			i2c_slv_pkg::OFS_CTRL: rd_val = q.ctrl;
			i2c_slv_pkg::OFS_STAT: rd_val = q.stat;
			i2c_slv_pkg::OFS_ADDR: rd_val = q.own;
			i2c_slv_pkg::OFS_DATA: rd_val = q.data;
			i2c_slv_pkg::OFS_TOUT: rd_val = {1'b0, q.tof, 5'h00, q.irq_en};
			default:               rd_val = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_q = q;
		next_q.irq = 1'b0;
		next_q.wake = 1'b0;
		if (setup)
			next_q.prdata = {24'h000000, rd_val};
		// Software first, so hardware events below win over a clear
		if (acc && pwrite)
		begin
			case (paddr)
				i2c_slv_pkg::OFS_CTRL: next_q.ctrl = pwdata[7:0] & i2c_slv_pkg::CTRL_WMASK;
				i2c_slv_pkg::OFS_STAT: next_q.stat = (q.stat & ~i2c_slv_pkg::STAT_WMASK) |
					(pwdata[7:0] & i2c_slv_pkg::STAT_WMASK);
				i2c_slv_pkg::OFS_ADDR: next_q.own = pwdata[7:0];
				i2c_slv_pkg::OFS_DATA: next_q.data = pwdata[7:0];
				i2c_slv_pkg::OFS_TOUT:
				begin
					next_q.tof = pwdata[i2c_slv_pkg::TOF_BIT];
					next_q.irq_en = pwdata[i2c_slv_pkg::IRQEN_BIT];
				end
				default: next_q.own = q.own;
			endcase
		end
		if (start_det)
		begin
			next_q.stat[i2c_slv_pkg::BUSY_BIT] = 1'b1; // [R13]
			next_q.stat[i2c_slv_pkg::ADDR_MATCHED_FLAG_BIT] = 1'b0;
			next_q.st = i2c_slv_pkg::ST_ADDR;
			next_q.cnt = 4'h0;
			next_q.sda_oe = 1'b0;
			next_q.scl_oe = 1'b0;
		end
		else if (stop_det)
		begin
			next_q.stat[i2c_slv_pkg::BUSY_BIT] = 1'b0;
			next_q.stat[i2c_slv_pkg::ADDR_MATCHED_FLAG_BIT] = 1'b0;
			next_q.st = i2c_slv_pkg::ST_IDLE;
			next_q.sda_oe = 1'b0;
			next_q.scl_oe = 1'b0;
		end
		else
		begin
			case (q.st)
				i2c_slv_pkg::ST_ADDR:
				begin
					if (scl_rise)
					begin
						next_q.shift = {q.shift[6:0], sda_f}; // [R9]
						next_q.cnt = q.cnt + 4'h1;
						if (q.cnt == i2c_slv_pkg::ADDR_LAST)
						begin
							if (q.shift[6:0] == q.own[7:1]) // [R9] [R17]
							begin
								next_q.stat[i2c_slv_pkg::ADDR_MATCHED_FLAG_BIT] = 1'b1; // [R10]
								next_q.stat[i2c_slv_pkg::DIR_BIT] = sda_f; // [R3] [R4]
								next_q.irq = q.irq_en; // [R10] [R12]
								// Enable bit is left alone for software
								next_q.wake = q.stat[i2c_slv_pkg::WAKE_BIT] & low_power; // [R5] [R6]
								next_q.st = i2c_slv_pkg::ST_ADDR_ACK;
							end
							else
								next_q.st = i2c_slv_pkg::ST_IDLE;
						end
					end
				end
				i2c_slv_pkg::ST_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						if (!q.sda_oe)
							next_q.sda_oe = 1'b1; // [R11]
						else
						begin
							next_q.sda_oe = 1'b0;
							next_q.scl_oe = 1'b1; // [R16]
							next_q.st = i2c_slv_pkg::ST_HOLD;
						end
					end
				end
				i2c_slv_pkg::ST_HOLD:
				begin
					// Firmware picks the direction from the flag
					if (data_wr && q.stat[i2c_slv_pkg::XMIT_BIT])
					begin
						next_q.shift = pwdata[7:0];
						next_q.sda_oe = ~pwdata[7]; // [R19]
						next_q.scl_oe = 1'b0; // [R16]
						next_q.cnt = 4'h0;
						next_q.stat[i2c_slv_pkg::HCF_BIT] = 1'b0;
						next_q.st = i2c_slv_pkg::ST_TX;
					end
					else if (data_rd && !q.stat[i2c_slv_pkg::XMIT_BIT])
					begin
						next_q.scl_oe = 1'b0; // [R16]
						next_q.cnt = 4'h0;
						next_q.stat[i2c_slv_pkg::HCF_BIT] = 1'b0;
						next_q.st = i2c_slv_pkg::ST_RX;
					end
				end
				i2c_slv_pkg::ST_RX:
				begin
					if (scl_rise)
					begin
						next_q.shift = {q.shift[6:0], sda_f}; // [R19]
						next_q.cnt = q.cnt + 4'h1;
					end
					else if (scl_fall && q.cnt == i2c_slv_pkg::RX_BITS)
					begin
						next_q.data = q.shift;
						next_q.stat[i2c_slv_pkg::HCF_BIT] = 1'b1;
						next_q.stat[i2c_slv_pkg::ADDR_MATCHED_FLAG_BIT] = 1'b0;
						next_q.irq = q.irq_en; // [R12]
						// Snapshot so a late write cannot move sda with scl high
						next_q.sda_oe = ~q.stat[i2c_slv_pkg::ACK_SEND_CTRL_BIT]; // [R1] [R2]
						next_q.st = i2c_slv_pkg::ST_RX_ACK;
					end
				end
				i2c_slv_pkg::ST_RX_ACK:
				begin
					if (scl_fall)
					begin
						next_q.sda_oe = 1'b0;
						if (q.sda_oe)
						begin
							next_q.scl_oe = 1'b1; // [R20]
							next_q.st = i2c_slv_pkg::ST_HOLD;
						end
						else
							next_q.st = i2c_slv_pkg::ST_IDLE;
					end
				end
				i2c_slv_pkg::ST_TX:
				begin
					if (scl_fall)
					begin
						if (q.cnt == i2c_slv_pkg::TX_LAST)
						begin
							next_q.sda_oe = 1'b0;
							next_q.st = i2c_slv_pkg::ST_TX_ACK;
						end
						else
						begin
							next_q.shift = {q.shift[6:0], 1'b0}; // [R19]
							next_q.sda_oe = ~q.shift[6];
							next_q.cnt = q.cnt + 4'h1;
						end
					end
				end
				i2c_slv_pkg::ST_TX_ACK:
				begin
					if (scl_rise)
					begin
						next_q.stat[i2c_slv_pkg::ACK_RECV_FLAG_BIT] = sda_f; // [R7]
						next_q.stat[i2c_slv_pkg::HCF_BIT] = 1'b1;
						next_q.stat[i2c_slv_pkg::ADDR_MATCHED_FLAG_BIT] = 1'b0;
						next_q.irq = q.irq_en; // [R12]
					end
					else if (scl_fall)
					begin
						if (!q.stat[i2c_slv_pkg::ACK_RECV_FLAG_BIT])
						begin
							next_q.scl_oe = 1'b1; // [R8] [R20]
							next_q.st = i2c_slv_pkg::ST_HOLD;
						end
						else
							next_q.st = i2c_slv_pkg::ST_IDLE; // [R8]
					end
				end
				i2c_slv_pkg::ST_IDLE:
					next_q.sda_oe = 1'b0;
				default:
					next_q.st = i2c_slv_pkg::ST_IDLE;
			endcase
		end
		if (timeout_evt)
		begin
			next_q.stat = i2c_slv_pkg::STAT_RST;
			next_q.tof = 1'b1;
			next_q.irq = q.irq_en; // [R12]
			next_q.st = i2c_slv_pkg::ST_IDLE;
			next_q.sda_oe = 1'b0;
			next_q.scl_oe = 1'b0;
		end
		// Disabled: flags to defaults, control bits kept
		if (!active)
		begin
			next_q.stat = (next_q.stat & i2c_slv_pkg::STAT_KEEP) |
				(i2c_slv_pkg::STAT_RST & ~i2c_slv_pkg::STAT_KEEP); // [R15]
			next_q.st = i2c_slv_pkg::ST_IDLE;
			next_q.sda_oe = 1'b0;
			next_q.scl_oe = 1'b0;
			next_q.irq = timeout_evt & q.irq_en;
			next_q.wake = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.st <= i2c_slv_pkg::ST_IDLE;
			q.ctrl <= i2c_slv_pkg::CTRL_RST;
			q.stat <= i2c_slv_pkg::STAT_RST;
			q.own <= i2c_slv_pkg::ADDR_RST;
		end
		else
			q <= next_q;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Open drain: the pins only ever pull low
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
	assign scl_oe   = q.scl_oe;
	assign sda_oe   = q.sda_oe;
	assign irq_req  = q.irq;
	assign wake_req = q.wake;
	assign prdata   = q.prdata;
	assign pready   = 1'b1;
	assign pslverr  = acc & ~mapped;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	start_busy_a: assert property (active && start_det && !timeout_evt |=> q.stat[5]) // [R13]
		else $error("start did not set bus busy");
	addr_dir_a: assert property (active && !start_det && !stop_det && !timeout_evt &&
		q.st == i2c_slv_pkg::ST_ADDR && scl_rise && q.cnt == 4'h7 && q.shift[6:0] == q.own[7:1]
		|=> q.stat[2] == $past(sda_f) && q.stat[6]) // [R3]
		else $error("direction or match flag not captured");
	match_irq_a: assert property ($rose(q.stat[6]) && q.irq_en |-> q.irq) // [R10]
		else $error("address match without interrupt");
	addr_ack_a: assert property (active && !start_det && !stop_det && !timeout_evt &&
		q.st == i2c_slv_pkg::ST_ADDR_ACK && !q.sda_oe && scl_fall |=> q.sda_oe) // [R11]
		else $error("address acknowledge lost");
	rx_ack_level_a: assert property (active && !start_det && !stop_det && !timeout_evt &&
		q.st == i2c_slv_pkg::ST_RX && scl_fall && q.cnt == 4'h8 |=> q.sda_oe == !$past(q.stat[3])) // [R1]
		else $error("acknowledge level differs from control bit");
	ack_recv_flag_sample_a: assert property (active && !start_det && !stop_det && !timeout_evt &&
		q.st == i2c_slv_pkg::ST_TX_ACK && scl_rise |=> q.stat[0] == $past(sda_f)) // [R7]
		else $error("received acknowledge not sampled");
	hold_scl_a: assert property (q.st == i2c_slv_pkg::ST_HOLD |-> q.scl_oe && !q.sda_oe) // [R16]
		else $error("clock not held in hold state");
	nack_release_a: assert property (q.st == i2c_slv_pkg::ST_TX_ACK && q.stat[0] && scl_fall &&
		active && !start_det && !stop_det && !timeout_evt |=> !q.sda_oe ##1 !q.sda_oe) // [R8]
		else $error("data line not released after no acknowledge");
	no_start_a: assert property ($rose(q.sda_oe) |-> !scl_f || q.scl_oe) // [R14]
		else $error("slave pulled data low with clock high");
	wake_match_a: assert property (q.wake |-> q.stat[1] && low_power && $rose(q.stat[6])) // [R5]
		else $error("wake without enabled address match");
endmodule

/* tb/i2c_master_model.sv */
// Behavioural two-wire bus master for the slave bench.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/100ps
module i2c_master_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low
);
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// One clock; waits on the line so a stretching slave is honoured
	task automatic clk_bit(input logic b, output logic s);
		sda_low = ~b;
		#31.2;
		scl_low = 1'b0;
		wait (scl === 1'b1);
		#60;
		s = sda;
		#2.5;
		scl_low = 1'b1;
		#31.3;
	endtask
	task automatic start();
		sda_low = 1'b1;
		#62.5;
		scl_low = 1'b1;
		#31.3;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		#31.2;
		scl_low = 1'b0;
		wait (scl === 1'b1);
		#31.3;
		sda_low = 1'b0;
		#62.5;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], s);
		clk_bit(1'b1, ack);
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, d[i]);
		clk_bit(ack, s);
	endtask
endmodule

/* tb/i2c_slave_tb.sv */
// Self-checking bench for the two-wire slave: APB firmware plus bus master.
// Assumes 100 MHz pclk and a 125 ns bus clock from the master model.
`timescale 1ns/100ps
module i2c_slave_tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, r, dat, rng = 32'hf894dbee;
	logic        pready, pslverr, err, scl_o, scl_oe, sda_o, sda_oe;
	logic        low_power = 0, timeout_evt = 0, irq_req, wake_req;
	logic        scl_w, sda_w, m_scl, m_sda, ack;
	logic [6:0]  own;
	logic [7:0]  b;
	int          miscompares = 0, compares = 0, irqs = 0, wakes = 0, cycles = 0, i0;
	// Open-drain lines with pull-ups
	assign scl_w = ~((scl_oe & ~scl_o) | m_scl);
	assign sda_w = ~((sda_oe & ~sda_o) | m_sda);
	i2c_slave i2c_slave_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe(sda_oe), .low_power(low_power), .timeout_evt(timeout_evt),
		.irq_req(irq_req), .wake_req(wake_req));
	i2c_master_model i2c_master_model_inst (.scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda));
	always #5 pclk = ~pclk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic d);
		return {a, d};
	endfunction
	task automatic wrap_up();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cycles++;
		if (irq_req === 1'b1)
			irqs++;
		if (wake_req === 1'b1)
			wakes++;
		if (cycles == 20000)
		begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Wait bounded only by the cycle ceiling
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic hold_wait();
		do @(posedge pclk); while (scl_oe !== 1'b1);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h00, 0);
		chk(r, 32'he0);
		apb(0, 8'h04, 0);
		chk(r, 32'h81);
		apb(0, 8'h08, 0);
		chk(r, 32'h0);
		apb(0, 8'h14, 0);
		chk({r[30:0], err}, 32'h1);
		// Four-cycle debounce stretches too late for a 62.5 ns low phase, so only none or two
		apb(1, 8'h00, 32'hc2 | ((xs() & 1) << 2));
		dat = xs();
		own = dat[6:0];
		apb(1, 8'h08, {24'h0, own, dat[7]});
		apb(1, 8'h10, 32'h1);
		dat = xs();
		// Master writes two bytes; second one refused by the slave
		low_power <= 1'b1;
		apb(1, 8'h04, 32'h02);
		i0 = irqs;
		fork
			begin
				i2c_master_model_inst.start();
				i2c_master_model_inst.wbyte(addr_byte(own, 1'b0), ack);
				chk(ack, 0);
				i2c_master_model_inst.wbyte(dat[7:0], ack);
				chk(ack, 0);
				i2c_master_model_inst.wbyte(dat[15:8], ack);
				chk(ack, 1);
				i2c_master_model_inst.stop();
			end
			begin
				hold_wait();
				apb(0, 8'h04, 0);
				chk(r & 32'h66, 32'h62);
				apb(0, 8'h0c, 0);
				hold_wait();
				chk(wakes, 1);
				apb(1, 8'h04, 32'h0a);
				apb(0, 8'h0c, 0);
				chk(r, {24'h0, dat[7:0]});
			end
		join
		apb(0, 8'h0c, 0);
		chk(r, {24'h0, dat[15:8]});
		apb(0, 8'h04, 0);
		chk(r & 32'h20, 0);
		chk(irqs - i0, 3);
		low_power <= 1'b0;
		apb(1, 8'h04, 0);
		apb(0, 8'h04, 0);
		chk(r & 32'h0a, 0);
		// Foreign address is left alone
		i0 = irqs;
		i2c_master_model_inst.start();
		i2c_master_model_inst.wbyte(addr_byte(own ^ 7'h40, 1'b0), ack);
		chk(ack, 1);
		i2c_master_model_inst.stop();
		chk(irqs - i0, 0);
		// Master reads two bytes, acks the first only
		fork
			begin
				i2c_master_model_inst.start();
				i2c_master_model_inst.wbyte(addr_byte(own, 1'b1), ack);
				chk(ack, 0);
				i2c_master_model_inst.rbyte(1'b0, b);
				chk(b, dat[23:16]);
				i2c_master_model_inst.rbyte(1'b1, b);
				chk(b, dat[31:24]);
			end
			begin
				hold_wait();
				apb(0, 8'h04, 0);
				chk(r & 32'h04, 32'h04);
				apb(1, 8'h04, 32'h10);
				apb(1, 8'h0c, {24'h0, dat[23:16]});
				hold_wait();
				apb(0, 8'h04, 0);
				chk(r & 32'h01, 0);
				apb(1, 8'h0c, {24'h0, dat[31:24]});
			end
		join
		apb(0, 8'h04, 0);
		chk(r & 32'h01, 1);
		chk(sda_oe, 0);
		i2c_master_model_inst.stop();
		chk(wakes, 1);
		// Time-out shares the interrupt and restores the status
		i0 = irqs;
		timeout_evt <= 1'b1;
		@(posedge pclk);
		timeout_evt <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(irqs - i0, 1);
		apb(0, 8'h10, 0);
		chk(r & 32'h40, 32'h40);
		apb(0, 8'h04, 0);
		chk(r, 32'h81);
		wrap_up();
	end
endmodule
